/* rtl/sac_store.sv */
// Purpose: Checked byte store: parity on every byte, address and boundary checks
// Assumes: One reference at a time; requester waits for done before the next
// Notes: Store array is not reset; reading an unwritten byte gives unknown parity
// Functional notes
// - Nine-bit byte, check bit leftmost
// - Write check bit makes ones count odd
// - Read flags error on even ones count
// - Addresses are 24-bit unsigned byte numbers
// - One byte per cycle, address plus one
// - Address beyond 65535 raises addressing exception
// - Operand addressed by its high-order byte
// - Half-word address divisible by two
// - Word address divisible by four
// - Double-word address divisible by eight
// - Misalignment is specification exception, never machine check
// - Operand data bits numbered from left
// - Variable fields skip the alignment check
`timescale 1ns/10ps
module sac_store
  import sac_pkg::*;
(
  input wire logic ce,       // Clock enable, freezes all state when low
  input wire logic inj_perr, // Inverts the generated check bit on writes
  sac_if.store bus           // Link to the requester
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_XFER,
    ST_DONE
  } sac_store_state_t;

  sac_store_state_t state_reg;
  sac_store_state_t state_next;

  logic [8:0] mem [0:SAC_MEM_DEPTH-1];

  logic [23:0] addr_reg;
  logic [SAC_CNT_W-1:0] cnt_reg;
  logic write_reg;
  logic exc_addr_reg;
  logic exc_spec_reg;
  logic mchk_reg;
  logic [8:0] rd_word_reg;
  logic rd_valid_reg;
  logic inj_perr_meta_reg;
  logic inj_perr_sync_reg;

  logic take;
  logic [SAC_CNT_W-1:0] nbytes;
  logic [24:0] last_sum;
  logic range_bad;
  logic align_bad;
  logic access;
  logic [SAC_IDX_W-1:0] idx;
  logic check_bit;
  logic cur_perr;

  assign bus.req_ready = (state_reg == ST_IDLE);
  assign take = ce && bus.req_valid && (state_reg == ST_IDLE);

  // Span of the reference, first byte at the given address
  assign nbytes = sac_nbytes(bus.req_kind, bus.req_len);
  assign last_sum = {1'b0, bus.req_addr} + 25'(nbytes) - 25'h0000001;

  // Every byte of the operand must lie inside the installed store
  assign range_bad = (bus.req_addr > SAC_ADDR_LIMIT) || (last_sum > SAC_ADDR_LIMIT_X);

  always_comb begin
    align_bad = 1'b0;
    case (bus.req_kind)
      SAC_KIND_HALF: align_bad = |(bus.req_addr[2:0] & SAC_HALF_MASK);
      SAC_KIND_WORD: align_bad = |(bus.req_addr[2:0] & SAC_WORD_MASK);
      SAC_KIND_DWORD: align_bad = |(bus.req_addr[2:0] & SAC_DWORD_MASK);
      SAC_KIND_VAR: align_bad = 1'b0;
      default: align_bad = 1'b0;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          // A failed check goes straight to done with no byte touched
          if (range_bad || align_bad) begin
            state_next = ST_DONE;
          end else begin
            state_next = ST_XFER;
          end
        end
      end
      ST_XFER: begin
        // Count holds the bytes still to move, this one included
        if (cnt_reg == SAC_N_BYTE) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge bus.clk_sys or negedge bus.reset_n) begin
    if (!bus.reset_n) begin
      state_reg <= ST_IDLE;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // Reference capture and byte sequencing
  always_ff @(posedge bus.clk_sys or negedge bus.reset_n) begin
    if (!bus.reset_n) begin
      addr_reg <= 24'h000000;
      cnt_reg <= 9'h000;
      write_reg <= 1'b0;
    end else if (ce) begin
      if (take) begin
        addr_reg <= bus.req_addr;
        cnt_reg <= nbytes;
        write_reg <= bus.req_write;
      end else if (state_reg == ST_XFER) begin
        addr_reg <= addr_reg + 24'h000001;
        cnt_reg <= cnt_reg - 9'h001;
      end
    end
  end

  // Program-check flags, held from acceptance until the next reference
  always_ff @(posedge bus.clk_sys or negedge bus.reset_n) begin
    if (!bus.reset_n) begin
      exc_addr_reg <= 1'b0;
      exc_spec_reg <= 1'b0;
    end else if (ce && take) begin
      exc_addr_reg <= range_bad;
      exc_spec_reg <= align_bad;
    end
  end

  assign access = (state_reg == ST_XFER);
  assign idx = addr_reg[SAC_IDX_W-1:0];

  // Inject input may come straight from a pin, so it is synchronised first
  always_ff @(posedge bus.clk_sys or negedge bus.reset_n) begin
    if (!bus.reset_n) begin
      inj_perr_meta_reg <= 1'b0;
      inj_perr_sync_reg <= 1'b0;
    end else if (ce) begin
      inj_perr_meta_reg <= inj_perr;
      inj_perr_sync_reg <= inj_perr_meta_reg;
    end
  end

  // Odd parity over nine bits; the inject input breaks it for testing
  assign check_bit = ~(^bus.wr_byte) ^ inj_perr_sync_reg;

  assign bus.wr_take = ce && access && write_reg;

  // Store array; only reached in the transfer state, so exceptions never touch it
  always_ff @(posedge bus.clk_sys) begin
    if (ce && access) begin
      if (write_reg) begin
        mem[idx] <= {check_bit, bus.wr_byte};
      end else begin
        rd_word_reg <= mem[idx];
      end
    end
  end

  always_ff @(posedge bus.clk_sys or negedge bus.reset_n) begin
    if (!bus.reset_n) begin
      rd_valid_reg <= 1'b0;
    end else if (ce) begin
      rd_valid_reg <= access && !write_reg;
    end
  end

  // Even count of ones in a fetched byte is a storage fault
  assign cur_perr = rd_valid_reg && !(^rd_word_reg);

  // Machine check collects faults of all bytes of the reference
  always_ff @(posedge bus.clk_sys or negedge bus.reset_n) begin
    if (!bus.reset_n) begin
      mchk_reg <= 1'b0;
    end else if (ce) begin
      // A fault seen in the same cycle as a clear is kept
      if (cur_perr) begin
        mchk_reg <= 1'b1;
      end else if (take) begin
        mchk_reg <= 1'b0;
      end
    end
  end

  assign bus.rd_valid = rd_valid_reg;
  assign bus.rd_byte = rd_word_reg[SAC_BYTE_W-1:0];
  assign bus.rd_perr = cur_perr;
  assign bus.done = (state_reg == ST_DONE);
  assign bus.exc_addr = exc_addr_reg;
  assign bus.exc_spec = exc_spec_reg;
  // Separate from the program checks; last byte counted in the done cycle
  assign bus.mchk = mchk_reg || cur_perr;

endmodule // sac_store

/* rtl/sac_pkg.sv */
// Purpose: Shared constants and types for the storage address and parity check
// Assumes: 24-bit byte addresses, 64 KiB installed store, one clock
// Notes: Operand kinds are used by both ends; the byte-count helper only by the store
package sac_pkg;

  localparam int SAC_ADDR_W = 24;
  localparam int SAC_IDX_W = 16;
  localparam int SAC_MEM_DEPTH = 65536;
  localparam int SAC_CNT_W = 9;
  localparam int SAC_CHK_POS = 8;
  localparam int SAC_BYTE_W = 8;
  localparam int SAC_DATA_W = 64;

  // Highest installed byte address, and the same at sum width
  localparam logic [23:0] SAC_ADDR_LIMIT = 24'h00FFFF;
  localparam logic [24:0] SAC_ADDR_LIMIT_X = 25'h000FFFF;

  // Low-order address bits that must be zero per operand kind
  localparam logic [2:0] SAC_HALF_MASK = 3'h1;
  localparam logic [2:0] SAC_WORD_MASK = 3'h3;
  localparam logic [2:0] SAC_DWORD_MASK = 3'h7;

  localparam logic [8:0] SAC_N_BYTE = 9'h001;
  localparam logic [8:0] SAC_N_HALF = 9'h002;
  localparam logic [8:0] SAC_N_WORD = 9'h004;
  localparam logic [8:0] SAC_N_DWORD = 9'h008;

  typedef enum logic [2:0] {
    SAC_KIND_BYTE,
    SAC_KIND_HALF,
    SAC_KIND_WORD,
    SAC_KIND_DWORD,
    SAC_KIND_VAR
  } sac_kind_t;

  // Bytes in a reference; a variable field carries length minus one
  function automatic logic [8:0] sac_nbytes(input sac_kind_t kind, input logic [7:0] len_code);
    case (kind)
      SAC_KIND_BYTE: sac_nbytes = SAC_N_BYTE;
      SAC_KIND_HALF: sac_nbytes = SAC_N_HALF;
      SAC_KIND_WORD: sac_nbytes = SAC_N_WORD;
      SAC_KIND_DWORD: sac_nbytes = SAC_N_DWORD;
      default: sac_nbytes = {1'b0, len_code} + SAC_N_BYTE;
    endcase
  endfunction

endpackage

/* rtl/sac_if.sv */
// Purpose: Link between the requesting control section and the checked store
// Assumes: Both ends run on clk_sys and share reset_n
// Notes: The store paces every byte; the requester only answers wr_take
`timescale 1ns/10ps
interface sac_if
  import sac_pkg::*;
(
  input logic clk_sys, // System clock
  input logic reset_n  // Asynchronous reset, active low
);

  logic req_valid;
  logic req_ready;
  logic req_write;
  sac_kind_t req_kind;
  logic [23:0] req_addr;
  logic [7:0] req_len;
  logic [7:0] wr_byte;
  logic wr_take;
  logic rd_valid;
  logic [7:0] rd_byte;
  logic rd_perr;
  logic done;
  logic exc_addr;
  logic exc_spec;
  logic mchk;

  modport ctrl (
    input clk_sys, reset_n,
    output req_valid, req_write, req_kind, req_addr, req_len, wr_byte,
    input req_ready, wr_take, rd_valid, rd_byte, rd_perr, done, exc_addr, exc_spec, mchk
  );

  modport store (
    input clk_sys, reset_n,
    input req_valid, req_write, req_kind, req_addr, req_len, wr_byte,
    output req_ready, wr_take, rd_valid, rd_byte, rd_perr, done, exc_addr, exc_spec, mchk
  );

endinterface

/* rtl/sac_ctrl.sv */
// Purpose: Requesting end: issues one storage reference and gathers its result
// Assumes: Same clock and clock enable as the store
// Notes: Fixed operands sit right-justified in op_wdata and rdata
`timescale 1ns/10ps
module sac_ctrl
  import sac_pkg::*;
(
  input wire logic ce,                  // Clock enable, freezes all state when low
  input wire logic start,               // Begin a reference, taken when not busy
  input wire logic op_write,            // 1 store, 0 fetch
  input wire sac_kind_t op_kind,        // Operand kind
  input wire logic [23:0] op_addr,      // Address of the high-order byte
  input wire logic [7:0] op_len,        // Variable field length minus one
  input wire logic [63:0] op_wdata,     // Store data
  output logic busy,                    // Reference in progress
  output logic done,                    // One-cycle pulse, results valid
  output logic [63:0] rdata,            // Fetched operand, right-justified
  output logic addr_exc,                // Addressing exception of last reference
  output logic spec_exc,                // Specification exception of last reference
  output logic mchk,                    // Machine check of last reference
  output logic byte_valid,              // One-cycle pulse per fetched byte
  output logic [7:0] byte_data,         // Fetched byte
  sac_if.ctrl bus                       // Link to the store
);

  typedef enum logic [1:0] {
    CT_IDLE,
    CT_REQ,
    CT_WAIT
  } sac_ctrl_state_t;

  sac_ctrl_state_t state_reg;
  logic write_reg;
  sac_kind_t kind_reg;
  logic [23:0] addr_reg;
  logic [7:0] len_reg;
  logic [63:0] shift_reg;
  logic [63:0] rdata_reg;
  logic done_reg;
  logic addr_exc_reg;
  logic spec_exc_reg;
  logic mchk_reg;
  logic byte_valid_reg;
  logic [7:0] byte_data_reg;
  logic [63:0] wd_aligned;

  // High-order byte goes out first
  always_comb begin
    wd_aligned = op_wdata;
    case (op_kind)
      SAC_KIND_BYTE: wd_aligned = {op_wdata[7:0], 56'h0};
      SAC_KIND_HALF: wd_aligned = {op_wdata[15:0], 48'h0};
      SAC_KIND_WORD: wd_aligned = {op_wdata[31:0], 32'h0};
      default: wd_aligned = op_wdata;
    endcase
  end

  always_ff @(posedge bus.clk_sys or negedge bus.reset_n) begin
    if (!bus.reset_n) begin
      state_reg <= CT_IDLE;
    end else if (ce) begin
      case (state_reg)
        CT_IDLE: if (start) state_reg <= CT_REQ;
        CT_REQ: if (bus.req_ready) state_reg <= CT_WAIT;
        CT_WAIT: if (bus.done) state_reg <= CT_IDLE;
        default: state_reg <= CT_IDLE;
      endcase
    end
  end

  always_ff @(posedge bus.clk_sys or negedge bus.reset_n) begin
    if (!bus.reset_n) begin
      write_reg <= 1'b0;
      kind_reg <= SAC_KIND_BYTE;
      addr_reg <= 24'h000000;
      len_reg <= 8'h00;
      shift_reg <= 64'h0;
    end else if (ce) begin
      if (state_reg == CT_IDLE && start) begin
        write_reg <= op_write;
        kind_reg <= op_kind;
        addr_reg <= op_addr;
        len_reg <= op_len;
        shift_reg <= wd_aligned;
      end else if (bus.wr_take) begin
        // Rotate so a long variable field repeats the eight data bytes
        shift_reg <= {shift_reg[55:0], shift_reg[63:56]};
      end
    end
  end

  // Fetched bytes enter from the right, first byte ends highest
  always_ff @(posedge bus.clk_sys or negedge bus.reset_n) begin
    if (!bus.reset_n) begin
      rdata_reg <= 64'h0;
      byte_valid_reg <= 1'b0;
      byte_data_reg <= 8'h00;
    end else if (ce) begin
      byte_valid_reg <= bus.rd_valid;
      if (bus.rd_valid) begin
        byte_data_reg <= bus.rd_byte;
      end
      if (state_reg == CT_IDLE && start) begin
        rdata_reg <= 64'h0;
      end else if (bus.rd_valid) begin
        rdata_reg <= {rdata_reg[55:0], bus.rd_byte};
      end
    end
  end

  always_ff @(posedge bus.clk_sys or negedge bus.reset_n) begin
    if (!bus.reset_n) begin
      done_reg <= 1'b0;
      addr_exc_reg <= 1'b0;
      spec_exc_reg <= 1'b0;
      mchk_reg <= 1'b0;
    end else if (ce) begin
      done_reg <= (state_reg == CT_WAIT) && bus.done;
      if (state_reg == CT_WAIT && bus.done) begin
        addr_exc_reg <= bus.exc_addr;
        spec_exc_reg <= bus.exc_spec;
        mchk_reg <= bus.mchk;
      end
    end
  end

  assign bus.req_valid = (state_reg == CT_REQ);
  assign bus.req_write = write_reg;
  assign bus.req_kind = kind_reg;
  assign bus.req_addr = addr_reg;
  assign bus.req_len = len_reg;
  assign bus.wr_byte = shift_reg[63:56];

  assign busy = (state_reg != CT_IDLE);
  assign done = done_reg;
  assign rdata = rdata_reg;
  assign addr_exc = addr_exc_reg;
  assign spec_exc = spec_exc_reg;
  assign mchk = mchk_reg;
  assign byte_valid = byte_valid_reg;
  assign byte_data = byte_data_reg;

endmodule // sac_ctrl

/* tb/sac_chk.sv */
// Purpose: Link-level checks between requester and store
// Assumes: One clock domain, reset_n asynchronous active low
// Notes: Sees only link signals; placed beside the link instance
`timescale 1ns/10ps
module sac_chk
  import sac_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Reset, active low
  input wire logic req_valid, // Request offered
  input wire logic req_ready, // Store idle
  input wire logic req_write, // Store when high
  input wire sac_kind_t req_kind, // Operand kind
  input wire logic [23:0] req_addr, // High-order byte address
  input wire logic wr_take, // Byte written
  input wire logic rd_valid, // Byte fetched
  input wire logic rd_perr, // Fetched byte parity bad
  input wire logic done, // Reference finished
  input wire logic exc_addr, // Addressing exception
  input wire logic exc_spec, // Specification exception
  input wire logic mchk // Machine check
);
  logic take;
  assign take = req_valid && req_ready;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_word_store;
    take && req_write && req_kind == SAC_KIND_WORD && req_addr[1:0] == 2'h0 &&
      req_addr <= 24'h00FFFC;
  endsequence
  sequence s_dword_fetch;
    take && !req_write && req_kind == SAC_KIND_DWORD && req_addr[2:0] == 3'h0 &&
      req_addr <= 24'h00FFF8;
  endsequence
  chk_half_align: assert property (take && req_kind == SAC_KIND_HALF && req_addr[0]
    |=> exc_spec) else $error("half-word misalignment not flagged");
  chk_word_align: assert property (take && req_kind == SAC_KIND_WORD
    && req_addr[1:0] != 2'h0 |=> exc_spec) else $error("word misalignment not flagged");
  chk_dword_align: assert property (take && req_kind == SAC_KIND_DWORD
    && req_addr[2:0] != 3'h0 |=> exc_spec) else $error("double-word misalignment not flagged");
  chk_var_free: assert property (take && req_kind == SAC_KIND_VAR |=> !exc_spec)
    else $error("variable field flagged for alignment");
  chk_addr_range: assert property (take && req_addr > SAC_ADDR_LIMIT |=> exc_addr)
    else $error("address beyond store not flagged");
  chk_byte_valid: assert property (take && req_kind == SAC_KIND_BYTE
    && req_addr <= SAC_ADDR_LIMIT |=> !exc_addr && !exc_spec) else $error("valid byte refused");
  chk_cycle_suppress: assert property (take ##1 (exc_addr || exc_spec)
    |-> done && !wr_take && !rd_valid) else $error("excepted reference touched store");
  chk_perr_mchk: assert property (rd_perr |=> mchk)
    else $error("parity error not held as machine check");
  chk_spec_no_mchk: assert property (exc_spec && done |-> !mchk)
    else $error("specification exception gave machine check");
  chk_word_bytes: assert property (s_word_store |=> wr_take [*4] ##1 done)
    else $error("word store not four byte cycles");
  chk_dword_bytes: assert property (s_dword_fetch |=> !rd_valid ##1 rd_valid [*8] ##0 done)
    else $error("double-word fetch not eight byte cycles");
endmodule // sac_chk

/* tb/test_storage_address_and_parity_check.sv */
// Purpose: Self-checking bench joining requester and store over the link
// Assumes: Both ends share clk_sys, reset_n and ce
// Notes: Bytes are written before being read, the array has no reset
`timescale 1ns/10ps
module test_storage_address_and_parity_check
  import sac_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic inj_perr = 1'b0;
  logic start = 1'b0;
  logic op_write = 1'b0;
  sac_kind_t op_kind = SAC_KIND_BYTE;
  logic [23:0] op_addr = 24'h000000;
  logic [7:0] op_len = 8'h00;
  logic [63:0] op_wdata = 64'h0;
  logic busy, done, addr_exc, spec_exc, mchk;
  logic byte_valid;
  logic [7:0] byte_data;
  logic [63:0] rdata;
  int n_errors = 0;
  int num_checks = 0;

  always #4 clk_sys = ~clk_sys;

  sac_if bus (.clk_sys(clk_sys), .reset_n(reset_n));
  sac_store u_sac_store (.ce(ce), .inj_perr(inj_perr), .bus(bus.store));
  sac_ctrl u_sac_ctrl (.ce(ce), .start(start), .op_write(op_write), .op_kind(op_kind),
    .op_addr(op_addr), .op_len(op_len), .op_wdata(op_wdata), .busy(busy), .done(done),
    .rdata(rdata), .addr_exc(addr_exc), .spec_exc(spec_exc), .mchk(mchk),
    .byte_valid(byte_valid), .byte_data(byte_data), .bus(bus.ctrl));
  sac_chk u_sac_chk (.clk_sys(clk_sys), .reset_n(reset_n), .req_valid(bus.req_valid),
    .req_ready(bus.req_ready), .req_write(bus.req_write), .req_kind(bus.req_kind),
    .req_addr(bus.req_addr), .wr_take(bus.wr_take), .rd_valid(bus.rd_valid),
    .rd_perr(bus.rd_perr), .done(bus.done), .exc_addr(bus.exc_addr), .exc_spec(bus.exc_spec),
    .mchk(bus.mchk));

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // One reference; flags are {addressing, specification, machine check}
  task automatic op(input logic w, input sac_kind_t k, input logic [23:0] a,
    input logic [7:0] l, input logic [63:0] d, input logic [63:0] exp,
    input logic [2:0] flags, input int nb);
    int cnt;
    int t;
    cnt = 0;
    t = 0;
    @(posedge clk_sys);
    #1;
    start = 1'b1;
    op_write = w;
    op_kind = k;
    op_addr = a;
    op_len = l;
    op_wdata = d;
    @(posedge clk_sys);
    #1;
    start = 1'b0;
    chk("busy", 64'h1, {63'h0, busy});
    // Byte strobes are counted mid-cycle, clear of the stimulus edge
    while (done !== 1'b1 && t < 300) begin
      @(negedge clk_sys);
      if (bus.wr_take === 1'b1 || bus.rd_valid === 1'b1) cnt++;
      @(posedge clk_sys);
      #1;
      t++;
    end
    chk("done", 64'h1, {63'h0, done});
    chk("busy", 64'h0, {63'h0, busy});
    if (!w) chk("rdata", exp, rdata);
    chk("flags", {61'h0, flags}, {61'h0, addr_exc, spec_exc, mchk});
    chk("byte count", 64'(nb), 64'(cnt));
    chk("byte valid", 64'(!w && nb > 0), {63'h0, byte_valid});
    if (!w && nb > 0) chk("byte data", {56'h0, exp[7:0]}, {56'h0, byte_data});
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #40000;
    n_errors++;
    results();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    op(1'h1, SAC_KIND_DWORD, 24'h000010, 8'h00, 64'h0123456789ABCDEF, 64'h0, 3'h0, 8);
    op(1'h0, SAC_KIND_DWORD, 24'h000010, 8'h00, 64'h0, 64'h0123456789ABCDEF, 3'h0, 8);
    op(1'h0, SAC_KIND_HALF, 24'h000012, 8'h00, 64'h0, 64'h4567, 3'h0, 2);
    op(1'h0, SAC_KIND_WORD, 24'h000014, 8'h00, 64'h0, 64'h89ABCDEF, 3'h0, 4);
    op(1'h0, SAC_KIND_VAR, 24'h000011, 8'h02, 64'h0, 64'h234567, 3'h0, 3);
    $display("test aligned access finished");
    op(1'h1, SAC_KIND_HALF, 24'h000011, 8'h00, 64'hFFFF, 64'h0, 3'h2, 0);
    op(1'h0, SAC_KIND_WORD, 24'h000012, 8'h00, 64'h0, 64'h0, 3'h2, 0);
    op(1'h0, SAC_KIND_DWORD, 24'h000014, 8'h00, 64'h0, 64'h0, 3'h2, 0);
    op(1'h0, SAC_KIND_BYTE, 24'h010000, 8'h00, 64'h0, 64'h0, 3'h4, 0);
    op(1'h1, SAC_KIND_WORD, 24'hFFFFFE, 8'h00, 64'hFF, 64'h0, 3'h6, 0);
    $display("test exceptions finished");
    op(1'h1, SAC_KIND_BYTE, 24'h00FFFF, 8'h00, 64'hA5, 64'h0, 3'h0, 1);
    op(1'h0, SAC_KIND_BYTE, 24'h00FFFF, 8'h00, 64'h0, 64'hA5, 3'h0, 1);
    op(1'h1, SAC_KIND_WORD, 24'h000014, 8'h00, 64'hDEADBEEF, 64'h0, 3'h0, 4);
    op(1'h0, SAC_KIND_DWORD, 24'h000010, 8'h00, 64'h0, 64'h01234567DEADBEEF, 3'h0, 8);
    // Clock enable dropped for three edges in the middle of a store
    fork
      op(1'h1, SAC_KIND_VAR, 24'h000030, 8'h03, 64'h1122334455667788, 64'h0, 3'h0, 4);
      begin
        repeat (4) @(posedge clk_sys);
        #1;
        ce = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        ce = 1'b1;
      end
    join
    op(1'h0, SAC_KIND_VAR, 24'h000030, 8'h03, 64'h0, 64'h11223344, 3'h0, 4);
    $display("test boundary and overwrite finished");
    inj_perr = 1'b1;
    op(1'h1, SAC_KIND_BYTE, 24'h000020, 8'h00, 64'h5A, 64'h0, 3'h0, 1);
    inj_perr = 1'b0;
    op(1'h0, SAC_KIND_BYTE, 24'h000020, 8'h00, 64'h0, 64'h5A, 3'h1, 1);
    op(1'h0, SAC_KIND_HALF, 24'h000010, 8'h00, 64'h0, 64'h0123, 3'h0, 2);
    $display("test parity finished");
    results();
  end
endmodule // test_storage_address_and_parity_check
